// ===== rtch_pkg.sv
package rtch_pkg;

    // Register byte addresses on the plain register port.
    localparam logic [15:0] HOUR_OFS = 16'h56c8;
    localparam logic [15:0] CTRL_OFS = 16'h56ca;
    localparam logic [15:0] STAT_OFS = 16'h56cc;
    localparam logic [15:0] MASK_OFS = 16'h56ce;

    // Field positions in the hour register.
    localparam int HOUR_LSB = 0;
    localparam int HOUR_MSB = 5;
    localparam int PM_BIT = 7;

    // Field positions in the clock control register.
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_FMT_BIT = 1;
    localparam int CTRL_BCD_BIT = 2;
    localparam int CTRL_W = 3;

    // Field positions in the status and mask registers.
    localparam int FLAG_HALF_BIT = 0;
    localparam int FLAG_DAY_BIT = 1;
    localparam int FLAG_W = 2;

    // Values after reset.
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [FLAG_W-1:0] FLAG_RST = 2'h0;
    localparam logic [FLAG_W-1:0] MASK_RST = 2'h0;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // Hour values that steer the count in each coding.
    localparam logic [5:0] BIN_H11 = 6'h0b;
    localparam logic [5:0] BIN_H12 = 6'h0c;
    localparam logic [5:0] BIN_H23 = 6'h17;
    localparam logic [5:0] BCD_H11 = 6'h11;
    localparam logic [5:0] BCD_H12 = 6'h12;
    localparam logic [5:0] BCD_H23 = 6'h23;
    localparam logic [5:0] H_ZERO = 6'h00;
    localparam logic [5:0] H_ONE = 6'h01;
    localparam logic [3:0] BCD_UNIT_MAX = 4'h9;

endpackage

// ===== rtch_step_if.sv
`timescale 1ns/1ps

// Carries the current hour state to the stepper and its next value back.
interface rtch_step_if;
    logic [5:0] hour;
    logic pm;
    logic fmt12;
    logic bcd;
    logic [5:0] nxt_hour;
    logic nxt_pm;
    logic half_day;
    logic one_day;

    modport core (output hour, pm, fmt12, bcd,
                  input nxt_hour, nxt_pm, half_day, one_day);
    modport stepper (input hour, pm, fmt12, bcd,
                     output nxt_hour, nxt_pm, half_day, one_day);
endinterface

// ===== rtch_hour_step.sv
`timescale 1ns/1ps

module rtch_hour_step (
    // Hour state in, next hour state out.
    rtch_step_if.stepper s
);

    logic [5:0] h11;
    logic [5:0] h12;
    logic [5:0] h23;

    // Turning points depend on the coding, so both codings share one path.
    always_comb begin
        h11 = s.bcd ? rtch_pkg::BCD_H11 : rtch_pkg::BIN_H11;
        h12 = s.bcd ? rtch_pkg::BCD_H12 : rtch_pkg::BIN_H12;
        h23 = s.bcd ? rtch_pkg::BCD_H23 : rtch_pkg::BIN_H23;
    end

    // One step of the hour count with its half-day and one-day events.
    always_comb begin
        s.nxt_pm = s.pm;
        s.half_day = 1'h0;
        s.one_day = 1'h0;
        if (!s.fmt12 && s.hour == h23) begin
            s.nxt_hour = rtch_pkg::H_ZERO;
            s.half_day = 1'h1;
            s.one_day = 1'h1;
        end else if (s.hour == h11) begin
            s.nxt_hour = h12;
            s.half_day = 1'h1;
            if (s.fmt12) begin
                s.nxt_pm = ~s.pm;
                s.one_day = s.pm;
            end
        end else if (s.fmt12 && s.hour == h12) begin
            s.nxt_hour = rtch_pkg::H_ONE;
        end else if (s.bcd && s.hour[3:0] == rtch_pkg::BCD_UNIT_MAX) begin
            // Units roll to zero and the tens digit takes the carry.
            s.nxt_hour = {s.hour[5:4] + 2'h1, 4'h0};
        end else begin
            s.nxt_hour = s.hour + 6'h01;
        end
    end

endmodule // rtch_hour_step

// ===== rtch_hour_counter.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// Function
// - Hour count sits in bits 5:0 of the hour register, read and write.
// - Bit 7 is the afternoon indicator in 12-hour format, 1 afternoon.
// - The afternoon indicator only means something while 12-hour is chosen.
// - In 24-hour format the afternoon indicator is held at zero.
// - Switching from 12-hour to 24-hour clears the indicator at once.
// - Binary 24-hour count runs 0x0 to 0x17.
// - Binary 12-hour count runs 0x1 to 0xc.
// - BCD 24-hour: tens digit 0 to 2, units digit 0 to 9.
// - BCD 12-hour: tens digit 0 or 1, units digit 0 to 9.
// - Reset leaves the hour count undefined; the indicator clears as reset picks 24-hour.
// - Only in-range values are written; out-of-range leaves count undefined.
// - A loaded value may raise an event right after the clock starts.
// - Coding select picks binary at 0, BCD at 1, for all counters.
// - One-day flag sets on 23 to 0, or 11 p.m. to 12 a.m.
// - Half-day flag sets on 11 to 12 and 23 to 0 transitions.
module rtch_hour_counter (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Register port.
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Carry from the minute counter, same clock.
    input wire logic minute_carry,
    // Control toward the rest of the clock.
    output logic clock_run,
    output logic hour_format_select,
    output logic count_coding_select,
    // Event flags and interrupt.
    output logic half_day_flag,
    output logic one_day_flag,
    output logic irq
);

    logic [rtch_pkg::CTRL_W-1:0] ctrl_r;
    logic [rtch_pkg::CTRL_W-1:0] ctrl_nxt;
    logic [5:0] hour_r;
    logic [5:0] hour_wval;
    logic pm_r;
    logic [rtch_pkg::FLAG_W-1:0] flag_r;
    logic [rtch_pkg::FLAG_W-1:0] flag_nxt;
    logic [rtch_pkg::FLAG_W-1:0] event_set;
    logic [rtch_pkg::FLAG_W-1:0] mask_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic wr_hour;
    logic wr_ctrl;
    logic wr_mask;
    logic rd_hour;
    logic rd_ctrl;
    logic rd_stat;
    logic rd_mask;
    logic fmt12;
    logic fmt12_nxt;
    logic bcd;
    logic advance;

    rtch_step_if step_bus ();

    // Address decode; every strobe selects at most one register.
    assign wr_hour = reg_wr && reg_addr == rtch_pkg::HOUR_OFS;
    assign wr_ctrl = reg_wr && reg_addr == rtch_pkg::CTRL_OFS;
    assign wr_mask = reg_wr && reg_addr == rtch_pkg::MASK_OFS;
    assign rd_hour = reg_rd && reg_addr == rtch_pkg::HOUR_OFS;
    assign rd_ctrl = reg_rd && reg_addr == rtch_pkg::CTRL_OFS;
    assign rd_stat = reg_rd && reg_addr == rtch_pkg::STAT_OFS;
    assign rd_mask = reg_rd && reg_addr == rtch_pkg::MASK_OFS;

    // Next control value, so that a format change acts in the same edge.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = reg_wdata[rtch_pkg::CTRL_W-1:0];
        end
    end

    // Control register: run, hour format and count coding.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r <= rtch_pkg::CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Decoded control fields.
    assign fmt12 = ctrl_r[rtch_pkg::CTRL_FMT_BIT];
    assign fmt12_nxt = ctrl_nxt[rtch_pkg::CTRL_FMT_BIT];
    assign bcd = ctrl_r[rtch_pkg::CTRL_BCD_BIT];
    assign clock_run = ctrl_r[rtch_pkg::CTRL_RUN_BIT];
    assign hour_format_select = fmt12;
    assign count_coding_select = bcd;

    // The count only moves on a minute wrap while the clock runs. A loaded
    // value is judged as it stands, so a carry right after start may fire
    // an event at once.
    assign advance = minute_carry && clock_run;

    // Hand the present state to the stepper.
    assign step_bus.hour = hour_r;
    assign step_bus.pm = pm_r;
    assign step_bus.fmt12 = fmt12;
    assign step_bus.bcd = bcd;

    rtch_hour_step u_step (
        .s(step_bus)
    );

    // Hour field of the write data.
    assign hour_wval = reg_wdata[rtch_pkg::HOUR_MSB:rtch_pkg::HOUR_LSB];

    // Hour count. It has no reset on purpose; software loads it. A write
    // wins over a step, since writes are meant for a stopped clock only.
    // Values are stored raw: range checking would cost logic and an
    // out-of-range load is software's fault.
    always_ff @(posedge core_clk) begin
        if (wr_hour) begin
            hour_r <= hour_wval;
        end else if (advance) begin
            hour_r <= step_bus.nxt_hour;
        end
    end

    // Afternoon indicator. Held at zero whenever the next format is
    // 24-hour, which also clears it in the very edge of a format change.
    always_ff @(posedge core_clk) begin
        if (!fmt12_nxt) begin
            pm_r <= 1'h0;
        end else if (wr_hour) begin
            pm_r <= reg_wdata[rtch_pkg::PM_BIT];
        end else if (advance) begin
            pm_r <= step_bus.nxt_pm;
        end
    end

    // Events from the stepper, qualified by a real step.
    assign event_set[rtch_pkg::FLAG_HALF_BIT] =
        advance && step_bus.half_day;
    assign event_set[rtch_pkg::FLAG_DAY_BIT] =
        advance && step_bus.one_day;

    // Sticky flags clear on a status read; a new event in that cycle wins.
    always_comb begin
        flag_nxt = flag_r;
        if (rd_stat) begin
            flag_nxt = {rtch_pkg::FLAG_W{1'h0}};
        end
        flag_nxt = flag_nxt | event_set;
    end

    // Status flags.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flag_r <= rtch_pkg::FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Interrupt mask, same layout as the status flags.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mask_r <= rtch_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_r <= reg_wdata[rtch_pkg::FLAG_W-1:0];
        end
    end

    // Flag outputs and the level interrupt.
    assign half_day_flag = flag_r[rtch_pkg::FLAG_HALF_BIT];
    assign one_day_flag = flag_r[rtch_pkg::FLAG_DAY_BIT];
    assign irq = |(flag_r & mask_r);

    // Read mux; unmapped addresses and reserved bits read as zero.
    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd_hour) begin
            rdata_nxt[rtch_pkg::HOUR_MSB:rtch_pkg::HOUR_LSB] = hour_r;
            rdata_nxt[rtch_pkg::PM_BIT] = pm_r;
        end else if (rd_ctrl) begin
            rdata_nxt[rtch_pkg::CTRL_W-1:0] = ctrl_r;
        end else if (rd_stat) begin
            rdata_nxt[rtch_pkg::FLAG_W-1:0] = flag_r;
        end else if (rd_mask) begin
            rdata_nxt[rtch_pkg::FLAG_W-1:0] = mask_r;
        end
    end

    // Read data stand for the one cycle after the strobe.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_r <= rtch_pkg::RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // Checks on the hour logic.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_step_at(logic [5:0] val);
        advance && hour_r == val;
    endsequence

    sequence s_bcd_unit_roll;
        advance && bcd && hour_r[3:0] == rtch_pkg::BCD_UNIT_MAX &&
            !(hour_r == rtch_pkg::BCD_H23 && !fmt12);
    endsequence

    a_hour_write_load: assert property (
        wr_hour |=> hour_r == $past(reg_wdata[5:0]))
        else $error("hour write not loaded");

    a_hour_read_back: assert property (
        rd_hour |=> reg_rdata[rtch_pkg::PM_BIT] == $past(pm_r))
        else $error("indicator read back wrong");

    a_reserved_zero: assert property (
        rd_hour |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[6])
        else $error("reserved bits not zero");

    a_pm_24h_zero: assert property (
        !fmt12 |-> !pm_r)
        else $error("indicator set in 24-hour format");

    a_fmt_drop_clear: assert property (
        wr_ctrl && fmt12 && !reg_wdata[1] |=> !pm_r && !fmt12)
        else $error("indicator not cleared on format change");

    a_bin24_wrap: assert property (
        s_step_at(rtch_pkg::BIN_H23) ##0 !bcd && !fmt12 && !wr_hour |=>
        hour_r == rtch_pkg::H_ZERO && one_day_flag && half_day_flag)
        else $error("binary 23 did not wrap with day event");

    a_bin12_wrap: assert property (
        s_step_at(rtch_pkg::BIN_H12) ##0 !bcd && fmt12 && !wr_hour |=>
        hour_r == rtch_pkg::H_ONE)
        else $error("binary 12 did not step to 1");

    a_bcd_roll: assert property (
        s_bcd_unit_roll ##0 !wr_hour |=>
        hour_r[3:0] == 4'h0 && hour_r[5:4] == $past(hour_r[5:4]) + 2'h1)
        else $error("BCD units did not roll");

    a_bcd12_wrap: assert property (
        s_step_at(rtch_pkg::BCD_H12) ##0 bcd && fmt12 && !wr_hour |=>
        hour_r == rtch_pkg::H_ONE)
        else $error("BCD 12 did not step to 01");

    a_pm_toggle: assert property (
        advance && fmt12 && !wr_hour && !wr_ctrl && hour_r ==
        (bcd ? rtch_pkg::BCD_H11 : rtch_pkg::BIN_H11) |=>
        pm_r != $past(pm_r))
        else $error("indicator did not toggle at 11 to 12");

    a_half_day_set: assert property (
        advance && hour_r == (bcd ? rtch_pkg::BCD_H11 : rtch_pkg::BIN_H11)
        |=> half_day_flag ##1 (half_day_flag || $past(rd_stat)))
        else $error("half-day flag not set");

    a_day_pm_only: assert property (
        advance && fmt12 && !pm_r && !rd_stat && !one_day_flag |=>
        !one_day_flag)
        else $error("day flag set in the morning");

    a_flag_set_wins: assert property (
        rd_stat && event_set[0] |=> half_day_flag)
        else $error("event lost under status read");

    a_hour_hold: assert property (
        !advance && !wr_hour |=> $stable(hour_r))
        else $error("hour moved without cause");

    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");

    a_bin24_range: assert property (
        advance && !bcd && !fmt12 && !wr_hour &&
        hour_r <= rtch_pkg::BIN_H23 |=> hour_r <= rtch_pkg::BIN_H23)
        else $error("binary 24-hour count left its range");

    a_bcd12_range: assert property (
        advance && bcd && fmt12 && !wr_hour &&
        hour_r <= rtch_pkg::BCD_H12 |=> hour_r <= rtch_pkg::BCD_H12)
        else $error("BCD 12-hour count left its range");

    a_day_24h_only: assert property (
        advance && !fmt12 && !one_day_flag &&
        hour_r != (bcd ? rtch_pkg::BCD_H23 : rtch_pkg::BIN_H23) |=>
        !one_day_flag)
        else $error("day flag set away from the wrap");

    a_status_clear: assert property (
        rd_stat && event_set == 2'h0 |=>
        !half_day_flag && !one_day_flag)
        else $error("status read did not clear flags");

endmodule // rtch_hour_counter

// ===== tb_top.sv
`timescale 1ns/1ps

module tb_top;
    // Clock and reset.
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    // Register port.
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    // Minute carry and outputs.
    logic minute_carry = 1'b0;
    logic clock_run;
    logic hour_format_select;
    logic count_coding_select;
    logic half_day_flag;
    logic one_day_flag;
    logic irq;
    int failures = 0;
    int n_checks = 0;
    logic [39:0] step;

    // Each entry: stopped ctrl, hour written, hour expected, status expected.
    localparam logic [39:0] STEPS [13] = '{
        40'h0_0017_0000_3, 40'h0_000b_000c_1, 40'h0_0005_0006_0,
        40'h2_008b_000c_3, 40'h2_000b_008c_1, 40'h2_000c_0001_0,
        40'h2_008c_0081_0, 40'h4_0009_0010_0, 40'h4_0011_0012_1,
        40'h4_0023_0000_3, 40'h6_0091_0012_3, 40'h6_0012_0001_0,
        40'h6_0009_0010_0};

    // The clock inverts every half period of 50 ns.
    always #50 core_clk = ~core_clk;

    rtch_hour_counter dut_u (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .minute_carry(minute_carry),
        .clock_run(clock_run), .hour_format_select(hour_format_select),
        .count_coding_select(count_coding_select),
        .half_day_flag(half_day_flag), .one_day_flag(one_day_flag),
        .irq(irq));

    // Compares one value and counts it.
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    // One-cycle write strobe; a gap cycle follows so strobes never merge.
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, then drop to 0.
    task automatic rd(input string name, input logic [15:0] addr,
                      input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
        @(posedge core_clk);
        #1;
        chk("rdata_idle", 16'h0000, reg_rdata);
    endtask

    // One minute-counter wrap; results are settled just after the edge.
    task automatic carry();
        @(posedge core_clk);
        minute_carry <= 1'b1;
        @(posedge core_clk);
        minute_carry <= 1'b0;
        #1;
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang is cut short here and counted against the run.
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk("ctrl_ports", 16'h0000, {13'h0, count_coding_select,
            hour_format_select, clock_run});
        rd("ctrl", rtch_pkg::CTRL_OFS, 16'h0000);
        rd("status", rtch_pkg::STAT_OFS, 16'h0000);
        rd("mask", rtch_pkg::MASK_OFS, 16'h0000);
        wr(16'h56d0, 16'hffff);
        rd("unmapped", 16'h56d0, 16'h0000);
        rd("ctrl_after_unmapped", rtch_pkg::CTRL_OFS, 16'h0000);
        wr(rtch_pkg::HOUR_OFS, 16'hff57);
        rd("hour_reserved", rtch_pkg::HOUR_OFS, 16'h0017);
        carry();
        rd("hour_stopped", rtch_pkg::HOUR_OFS, 16'h0017);
        rd("status_stopped", rtch_pkg::STAT_OFS, 16'h0000);
        wr(rtch_pkg::MASK_OFS, 16'hffff);
        rd("mask_set", rtch_pkg::MASK_OFS, 16'h0003);
        // Every coding and format; the clock is stopped for each load.
        for (int i = 0; i < 13; i++) begin
            step = STEPS[i];
            wr(rtch_pkg::CTRL_OFS, {12'h0, step[39:36]});
            wr(rtch_pkg::HOUR_OFS, step[35:20]);
            wr(rtch_pkg::CTRL_OFS, {12'h0, step[39:36] | 4'h1});
            chk("ctrl_ports", {12'h0, step[39:36] | 4'h1}, {13'h0,
                count_coding_select, hour_format_select, clock_run});
            carry();
            chk("flags", {12'h0, step[3:0]}, {14'h0, one_day_flag,
                half_day_flag});
            chk("irq", {15'h0, |step[3:0]}, {15'h0, irq});
            rd("hour_step", rtch_pkg::HOUR_OFS, step[19:4]);
            rd("status", rtch_pkg::STAT_OFS, step[15:0] & 16'h000f);
            rd("status_clear", rtch_pkg::STAT_OFS, 16'h0000);
            chk("irq_clear", 16'h0000, {15'h0, irq});
        end
        // Leaving 12-hour format drops the afternoon indicator at once.
        wr(rtch_pkg::CTRL_OFS, 16'h0002);
        wr(rtch_pkg::HOUR_OFS, 16'h0085);
        rd("hour_pm", rtch_pkg::HOUR_OFS, 16'h0085);
        wr(rtch_pkg::CTRL_OFS, 16'h0000);
        rd("hour_24h", rtch_pkg::HOUR_OFS, 16'h0005);
        wr(rtch_pkg::HOUR_OFS, 16'h0017);
        rd("pm_held", rtch_pkg::HOUR_OFS, 16'h0017);
        // A masked event sets its flag but leaves the interrupt low.
        wr(rtch_pkg::MASK_OFS, 16'h0002);
        wr(rtch_pkg::HOUR_OFS, 16'h000b);
        wr(rtch_pkg::CTRL_OFS, 16'h0001);
        carry();
        chk("irq_masked", 16'h0000, {15'h0, irq});
        chk("half_flag", 16'h0001, {15'h0, half_day_flag});
        rd("status_masked", rtch_pkg::STAT_OFS, 16'h0001);
        // Loaded value already at the wrap point raises an event at once.
        wr(rtch_pkg::CTRL_OFS, 16'h0000);
        wr(rtch_pkg::HOUR_OFS, 16'h0017);
        wr(rtch_pkg::CTRL_OFS, 16'h0001);
        carry();
        chk("irq_day", 16'h0001, {15'h0, irq});
        rd("status_day", rtch_pkg::STAT_OFS, 16'h0003);
        // A status read in the very cycle of an event must keep the event.
        wr(rtch_pkg::CTRL_OFS, 16'h0000);
        wr(rtch_pkg::HOUR_OFS, 16'h000b);
        wr(rtch_pkg::CTRL_OFS, 16'h0001);
        @(posedge core_clk);
        minute_carry <= 1'b1;
        reg_rd <= 1'b1;
        reg_addr <= rtch_pkg::STAT_OFS;
        @(posedge core_clk);
        minute_carry <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk("status_race", 16'h0000, reg_rdata);
        chk("half_kept", 16'h0001, {15'h0, half_day_flag});
        rd("status_kept", rtch_pkg::STAT_OFS, 16'h0001);
        final_report();
    end
endmodule // tb_top
